// File: design/arith_opcode_decoder.v
// Arithmetic group and segment prefix decoder with clock-count model
// Contract
// - The four one-byte segment prefixes are recognised, cost 2 clocks and set the next operand segment.
// - The sum register/memory form with direction and width bits plus a mode byte costs 3 or 10 clocks.
// - Sum with carry has its own register/memory and accumulator opcodes plus immediate extension 010.
// - Difference decodes from its own opcodes and immediate extension 101 with the same clock counts.
// - Difference with borrow decodes from its own opcodes and immediate extension 011.
// - Sign flip is group opcode 1111011w extension 011 at 3 or 10 clocks.
// - The ASCII adjust after a sum is one byte and takes 8 clocks.
// - The BCD adjust after a sum is one byte and takes 4 clocks.
// - The ASCII adjust after a difference is one byte and takes 7 clocks.
// - The BCD adjust after a difference is one byte and takes 4 clocks.
// - Unsigned product is 1111011w extension 100 with its four clock ranges.
// - Memory clock counts marked as byte figures are treated as byte figures.
// - Word memory transfers add four clocks to the byte figure.
`timescale 1ns/100ps
`default_nettype none
`include "arith_decoder_consts.vh"

module arith_opcode_decoder (
  input  wire       mclk,
  input  wire       nrst,
  input  wire       byte_valid,
  input  wire [7:0] byte_data,
  output wire       byte_ready,
  output reg        op_valid,
  input  wire       op_ready,
  output reg  [4:0] op_code,
  output reg        op_word,
  output reg        op_mem,
  output reg        op_dir,
  output reg        op_writes,
  output reg  [7:0] op_modrm,
  output reg  [15:0] op_imm,
  output reg        op_seg_valid,
  output reg  [1:0] op_seg,
  output reg  [5:0] op_clk_min,
  output reg  [5:0] op_clk_max,
  output reg        op_unknown
);

  reg  [1:0] state;
  reg  [7:0] opc;
  reg        imm_hi_needed;
  reg        seg_pending;
  reg  [1:0] seg_sel;
  wire       take;
  wire       mod_mem;
  wire [2:0] ext;

  // Stall the queue while a decoded op waits for the execution unit
  assign byte_ready = !op_valid || op_ready;
  assign take       = byte_valid && byte_ready;
  assign mod_mem    = byte_data[7:6] != `MOD_REG;
  assign ext        = byte_data[5:3];

  // Word memory adder applied on top of byte figures
  function [5:0] mem_word;
    input [5:0] base;
    input       word;
    input       mem;
    begin
      mem_word = (word && mem) ? base + `CLK_WORD_ADD : base;
    end
  endfunction

  // Decoder sequencer and output registers
  always @(posedge mclk) begin
    if (!nrst) begin
      state         <= `ST_OPC;
      opc           <= 8'h00;
      imm_hi_needed <= 1'b0;
      seg_pending   <= 1'b0;
      seg_sel       <= `SEG_DATA;
      op_valid      <= 1'b0;
      op_code       <= `OP_NONE;
      op_word       <= 1'b0;
      op_mem        <= 1'b0;
      op_dir        <= 1'b0;
      op_writes     <= 1'b0;
      op_modrm      <= 8'h00;
      op_imm        <= 16'h0000;
      op_seg_valid  <= 1'b0;
      op_seg        <= `SEG_DATA;
      op_clk_min    <= 6'h00;
      op_clk_max    <= 6'h00;
      op_unknown    <= 1'b0;
    end else begin
      if (op_valid && op_ready)
        op_valid <= 1'b0;
      if (take) begin
        case (state)
          `ST_OPC: begin
            opc        <= byte_data;
            op_word    <= byte_data[0];
            op_dir     <= byte_data[1];
            op_mem     <= 1'b0;
            op_modrm   <= 8'h00;
            op_imm     <= 16'h0000;
            op_writes  <= 1'b1;
            op_unknown <= 1'b0;
            op_seg_valid <= seg_pending;
            op_seg     <= seg_sel;
            if (byte_data == `PFX_CODE || byte_data == `PFX_STACK ||
                byte_data == `PFX_DATA || byte_data == `PFX_EXTRA) begin
              // Prefix reported on its own, segment held for next op
              seg_pending <= 1'b1;
              case (byte_data)
                `PFX_CODE:  seg_sel <= `SEG_CODE;
                `PFX_STACK: seg_sel <= `SEG_STACK;
                `PFX_DATA:  seg_sel <= `SEG_DATA;
                default:    seg_sel <= `SEG_EXTRA;
              endcase
              op_code    <= `OP_SEG;
              op_writes  <= 1'b0;
              op_seg_valid <= 1'b0;
              op_clk_min <= `CLK_SEG;
              op_clk_max <= `CLK_SEG;
              op_valid   <= 1'b1;
            end else begin
              seg_pending <= 1'b0;
              if (byte_data == `OPC_ASCII_SUM || byte_data == `OPC_BCD_SUM ||
                  byte_data == `OPC_ASCII_DIF || byte_data == `OPC_BCD_DIF)
                begin
                op_valid <= 1'b1;
                op_word  <= 1'b0;
                case (byte_data)
                  `OPC_ASCII_SUM: begin
                    op_code    <= `OP_ASCII_SUM;
                    op_clk_min <= `CLK_ASCII_S;
                    op_clk_max <= `CLK_ASCII_S;
                  end
                  `OPC_BCD_SUM: begin
                    op_code    <= `OP_BCD_SUM;
                    op_clk_min <= `CLK_BCD;
                    op_clk_max <= `CLK_BCD;
                  end
                  `OPC_ASCII_DIF: begin
                    op_code    <= `OP_ASCII_DIF;
                    op_clk_min <= `CLK_ASCII_D;
                    op_clk_max <= `CLK_ASCII_D;
                  end
                  default: begin
                    op_code    <= `OP_BCD_DIF;
                    op_clk_min <= `CLK_BCD;
                    op_clk_max <= `CLK_BCD;
                  end
                endcase
              end else if (byte_data[7:4] == `FAM_STEP) begin
                // One-byte register step up / step down, word wide
                op_code    <= byte_data[3] ? `OP_STEP_DOWN : `OP_STEP_UP;
                op_word    <= 1'b1;
                op_modrm   <= {5'h18, byte_data[2:0]};
                op_clk_min <= `CLK_RR_REG;
                op_clk_max <= `CLK_RR_REG;
                op_valid   <= 1'b1;
              end else if (byte_data[2:1] == 2'h2 &&
                           (byte_data[7:2] == {`ACC_SUM, 1'b1} ||
                            byte_data[7:2] == {`ACC_SUMC, 1'b1} ||
                            byte_data[7:2] == {`ACC_DIFF, 1'b1} ||
                            byte_data[7:2] == {`ACC_DIFB, 1'b1} ||
                            byte_data[7:2] == {`ACC_CMP, 1'b1})) begin
                // Accumulator-immediate forms
                case (byte_data[7:3])
                  `ACC_SUM:  op_code <= `OP_SUM;
                  `ACC_SUMC: op_code <= `OP_SUM_CARRY;
                  `ACC_DIFF: op_code <= `OP_DIFF;
                  `ACC_DIFB: op_code <= `OP_DIFF_BORR;
                  default: begin
                    op_code   <= `OP_COMPARE;
                    op_writes <= 1'b0;
                  end
                endcase
                op_clk_min <= byte_data[0] ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
                op_clk_max <= byte_data[0] ? `CLK_ACC_WORD : `CLK_ACC_BYTE;
                imm_hi_needed <= byte_data[0];
                state <= `ST_IMM_LO;
              end else if (byte_data[7:2] == `FAM_SUM ||
                           byte_data[7:2] == `FAM_SUMC ||
                           byte_data[7:2] == `FAM_DIFF ||
                           byte_data[7:2] == `FAM_DIFB ||
                           byte_data[7:2] == `FAM_CMP ||
                           byte_data[7:2] == `FAM_IMM ||
                           byte_data[7:1] == `FAM_GRP3 ||
                           byte_data[7:1] == `FAM_GRP4) begin
                state <= `ST_MODRM;
              end else begin
                op_code    <= `OP_NONE;
                op_unknown <= 1'b1;
                op_clk_min <= 6'h00;
                op_clk_max <= 6'h00;
                op_valid   <= 1'b1;
              end
            end
          end
          `ST_MODRM: begin
            op_modrm <= byte_data;
            op_mem   <= mod_mem;
            state    <= `ST_OPC;
            op_valid <= 1'b1;
            if (opc[7:2] == `FAM_IMM) begin
              // Immediate group; high byte only for s,w = 01
              imm_hi_needed <= opc[1:0] == 2'h1;
              state    <= `ST_IMM_LO;
              op_valid <= 1'b0;
              op_clk_min <= mod_mem ?
                mem_word(`CLK_IMM_MEM, opc[0], 1'b1) : `CLK_IMM_REG;
              op_clk_max <= mod_mem ?
                mem_word(`CLK_IMM_MEM, opc[0], 1'b1) : `CLK_IMM_REG;
              case (ext)
                `EXT_SUM:  op_code <= `OP_SUM;
                `EXT_SUMC: op_code <= `OP_SUM_CARRY;
                `EXT_DIFB: op_code <= `OP_DIFF_BORR;
                `EXT_DIFF: op_code <= `OP_DIFF;
                `EXT_CMP: begin
                  op_code    <= `OP_COMPARE;
                  op_writes  <= 1'b0;
                  op_clk_min <= mod_mem ?
                    mem_word(`CLK_RR_MEM, opc[0], 1'b1) : `CLK_RR_REG;
                  op_clk_max <= mod_mem ?
                    mem_word(`CLK_RR_MEM, opc[0], 1'b1) : `CLK_RR_REG;
                end
                default: begin
                  op_code    <= `OP_NONE;
                  op_unknown <= 1'b1;
                end
              endcase
            end else if (opc[7:1] == `FAM_GRP3) begin
              case (ext)
                `EXT_FLIP: begin
                  op_code    <= `OP_SIGN_FLIP;
                  op_clk_min <= mod_mem ?
                    mem_word(`CLK_RR_MEM, opc[0], 1'b1) : `CLK_RR_REG;
                  op_clk_max <= mod_mem ?
                    mem_word(`CLK_RR_MEM, opc[0], 1'b1) : `CLK_RR_REG;
                end
                `EXT_PROD: begin
                  // Product figures already cover word memory forms
                  op_code <= `OP_PRODUCT;
                  op_clk_min <= mod_mem ?
                    (opc[0] ? `CLK_PMW_MIN : `CLK_PMB_MIN) :
                    (opc[0] ? `CLK_PRW_MIN : `CLK_PRB_MIN);
                  op_clk_max <= mod_mem ?
                    (opc[0] ? `CLK_PMW_MAX : `CLK_PMB_MAX) :
                    (opc[0] ? `CLK_PRW_MAX : `CLK_PRB_MAX);
                end
                default: begin
                  op_code    <= `OP_NONE;
                  op_unknown <= 1'b1;
                  op_clk_min <= 6'h00;
                  op_clk_max <= 6'h00;
                end
              endcase
            end else if (opc[7:1] == `FAM_GRP4) begin
              if (ext == `EXT_SUM || ext == `EXT_STEPD) begin
                op_code <= ext[0] ? `OP_STEP_DOWN : `OP_STEP_UP;
                op_clk_min <= mod_mem ?
                  mem_word(`CLK_STEP_MEM, opc[0], 1'b1) : `CLK_RR_REG;
                op_clk_max <= mod_mem ?
                  mem_word(`CLK_STEP_MEM, opc[0], 1'b1) : `CLK_RR_REG;
              end else begin
                op_code    <= `OP_NONE;
                op_unknown <= 1'b1;
                op_clk_min <= 6'h00;
                op_clk_max <= 6'h00;
              end
            end else begin
              // Two-operand register/memory forms
              case (opc[7:2])
                `FAM_SUM:  op_code <= `OP_SUM;
                `FAM_SUMC: op_code <= `OP_SUM_CARRY;
                `FAM_DIFF: op_code <= `OP_DIFF;
                `FAM_DIFB: op_code <= `OP_DIFF_BORR;
                default: begin
                  op_code   <= `OP_COMPARE;
                  op_writes <= 1'b0;
                end
              endcase
              op_clk_min <= mod_mem ?
                mem_word(`CLK_RR_MEM, opc[0], 1'b1) : `CLK_RR_REG;
              op_clk_max <= mod_mem ?
                mem_word(`CLK_RR_MEM, opc[0], 1'b1) : `CLK_RR_REG;
            end
          end
          `ST_IMM_LO: begin
            op_imm <= {{8{byte_data[7]}}, byte_data}; // Sign-extend s=1
            if (imm_hi_needed) begin
              state <= `ST_IMM_HI;
            end else begin
              state    <= `ST_OPC;
              op_valid <= 1'b1;
            end
          end
          `ST_IMM_HI: begin
            op_imm[15:8] <= byte_data;
            state    <= `ST_OPC;
            op_valid <= 1'b1;
          end
          default: state <= `ST_OPC;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// File: design/arith_decoder_consts.vh
// Constants for the arithmetic opcode decoder
`ifndef ARITH_DECODER_CONSTS_VH
`define ARITH_DECODER_CONSTS_VH
// Operation codes reported to the execution unit
`define OP_NONE      5'h00
`define OP_SEG       5'h01
`define OP_SUM       5'h02
`define OP_SUM_CARRY 5'h03
`define OP_DIFF      5'h04
`define OP_DIFF_BORR 5'h05
`define OP_STEP_UP   5'h06
`define OP_STEP_DOWN 5'h07
`define OP_COMPARE   5'h08
`define OP_SIGN_FLIP 5'h09
`define OP_ASCII_SUM 5'h0a
`define OP_BCD_SUM   5'h0b
`define OP_ASCII_DIF 5'h0c
`define OP_BCD_DIF   5'h0d
`define OP_PRODUCT   5'h0e
// Prefix bytes
`define PFX_CODE  8'h2e
`define PFX_STACK 8'h36
`define PFX_DATA  8'h3e
`define PFX_EXTRA 8'h26
// Segment codes
`define SEG_EXTRA 2'h0
`define SEG_CODE  2'h1
`define SEG_STACK 2'h2
`define SEG_DATA  2'h3
// Single-byte adjust opcodes
`define OPC_ASCII_SUM 8'h37
`define OPC_BCD_SUM   8'h27
`define OPC_ASCII_DIF 8'h3f
`define OPC_BCD_DIF   8'h2f
// Opcode families, upper bits
`define FAM_SUM   6'h00
`define FAM_SUMC  6'h04
`define FAM_DIFF  6'h0a
`define FAM_DIFB  6'h06
`define FAM_CMP   6'h0e
`define FAM_IMM   6'h20
`define FAM_GRP3  7'h7b
`define FAM_GRP4  7'h7f
`define FAM_STEP  4'h4
// Accumulator-immediate families, opcode bits 7..3
`define ACC_SUM   5'h00
`define ACC_SUMC  5'h02
`define ACC_DIFF  5'h05
`define ACC_DIFB  5'h03
`define ACC_CMP   5'h07
// Extension field values
`define EXT_SUM   3'h0
`define EXT_STEPD 3'h1
`define EXT_SUMC  3'h2
`define EXT_DIFB  3'h3
`define EXT_FLIP  3'h3
`define EXT_PROD  3'h4
`define EXT_DIFF  3'h5
`define EXT_CMP   3'h7
`define MOD_REG   2'h3
// Clock counts
`define CLK_SEG      6'h02
`define CLK_RR_REG   6'h03
`define CLK_RR_MEM   6'h0a
`define CLK_IMM_REG  6'h04
`define CLK_IMM_MEM  6'h10
`define CLK_ACC_BYTE 6'h03
`define CLK_ACC_WORD 6'h04
`define CLK_STEP_MEM 6'h0f
`define CLK_ASCII_S  6'h08
`define CLK_BCD      6'h04
`define CLK_ASCII_D  6'h07
`define CLK_PRB_MIN  6'h1a
`define CLK_PRB_MAX  6'h1c
`define CLK_PRW_MIN  6'h23
`define CLK_PRW_MAX  6'h25
`define CLK_PMB_MIN  6'h20
`define CLK_PMB_MAX  6'h22
`define CLK_PMW_MIN  6'h29
`define CLK_PMW_MAX  6'h2b
`define CLK_WORD_ADD 6'h04
// Decoder states
`define ST_OPC  2'h0
`define ST_MODRM 2'h1
`define ST_IMM_LO 2'h2
`define ST_IMM_HI 2'h3
`endif

// File: verification/arith_decoder_checker.sv
// Port assertions for the arithmetic opcode decoder
`timescale 1ns/100ps
`default_nettype none
`include "arith_decoder_consts.vh"
module arith_decoder_checker (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       byte_valid,
  input wire logic       byte_ready,
  input wire logic       op_valid,
  input wire logic       op_ready,
  input wire logic [4:0] op_code,
  input wire logic       op_word,
  input wire logic       op_mem,
  input wire logic       op_writes,
  input wire logic [5:0] op_clk_min,
  input wire logic [5:0] op_clk_max,
  input wire logic       op_unknown
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Op offered but the execution unit is not taking it
  sequence s_held;
    op_valid && !op_ready;
  endsequence
  // Op taken with no byte queued behind it
  sequence s_drained;
    op_valid && op_ready && !byte_valid;
  endsequence
  chk_held_stable: assert property (s_held |=> op_valid
    && $stable(op_code) && $stable(op_clk_min))
    else $error("op changed while held");
  chk_queue_back: assert property (s_held |-> !byte_ready)
    else $error("byte taken while op held");
  chk_drain_clears: assert property (s_drained |=> !op_valid)
    else $error("op repeated after accept");
  chk_prefix_cost: assert property (op_valid && op_code == `OP_SEG
    |-> op_clk_min == 6'h02 && op_clk_max == 6'h02 && !op_writes)
    else $error("prefix cost wrong");
  chk_ascii_sum: assert property (op_valid && op_code == `OP_ASCII_SUM
    |-> op_clk_min == 6'h08 && op_clk_max == 6'h08)
    else $error("ascii sum fix cost wrong");
  chk_bcd_cost: assert property (op_valid && op_code inside {`OP_BCD_SUM,
    `OP_BCD_DIF} |-> op_clk_min == 6'h04 && op_clk_max == 6'h04)
    else $error("bcd fix cost wrong");
  chk_ascii_dif: assert property (op_valid && op_code == `OP_ASCII_DIF
    |-> op_clk_min == 6'h07 && op_clk_max == 6'h07)
    else $error("ascii difference fix cost wrong");
  chk_flip_cost: assert property (op_valid && op_code == `OP_SIGN_FLIP
    |-> op_clk_min == (op_mem ? (op_word ? 6'h0e : 6'h0a) : 6'h03))
    else $error("sign flip cost wrong");
  chk_product_span: assert property (op_valid && op_code == `OP_PRODUCT
    |-> op_clk_max == op_clk_min + 6'h02 && op_clk_min == (op_mem
    ? (op_word ? 6'h29 : 6'h20) : (op_word ? 6'h23 : 6'h1a)))
    else $error("product cost wrong");
  chk_step_cost: assert property (op_valid && op_code inside {`OP_STEP_UP,
    `OP_STEP_DOWN} |-> op_clk_min == (op_mem
    ? (op_word ? 6'h13 : 6'h0f) : 6'h03))
    else $error("step cost wrong");
  chk_compare_quiet: assert property (op_valid && op_code == `OP_COMPARE
    |-> !op_writes && (!op_mem || op_clk_min == (op_word ? 6'h0e : 6'h0a)))
    else $error("compare wrong");
  chk_unknown_code: assert property (op_valid && op_unknown |-> op_code == `OP_NONE)
    else $error("unknown op carries a code");
endmodule
bind arith_opcode_decoder arith_decoder_checker arith_decoder_checker_inst (
  .mclk(mclk), .nrst(nrst), .byte_valid(byte_valid),
  .byte_ready(byte_ready), .op_valid(op_valid), .op_ready(op_ready),
  .op_code(op_code), .op_word(op_word), .op_mem(op_mem),
  .op_writes(op_writes), .op_clk_min(op_clk_min),
  .op_clk_max(op_clk_max), .op_unknown(op_unknown));
`default_nettype wire

// File: verification/byte_queue_model.sv
// Prefetch queue model that offers bytes to the decoder
`timescale 1ns/100ps
`default_nettype none
module byte_queue_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       push,
  input  wire logic [7:0] push_byte,
  input  wire logic       gap,
  input  wire logic       byte_ready,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] q [0:31];
  logic [4:0] rd;
  logic [4:0] wr;
  logic [7:0] last;
  // Gap lets the bench play a slow queue
  assign byte_valid = (rd != wr) && !gap;
  // Idle data is inverted so a stale byte never looks valid
  assign byte_data = byte_valid ? q[rd] : ~last;
  // Fill from the bench, drain on each accepted byte
  always @(posedge mclk) begin
    if (!nrst) begin
      rd <= 5'h00;
      wr <= 5'h00;
      last <= 8'h00;
    end else begin
      if (push) begin
        q[wr] <= push_byte;
        wr <= wr + 5'h01;
      end
      if (byte_valid && byte_ready) begin
        rd <= rd + 5'h01;
        last <= q[rd];
      end
    end
  end
endmodule
`default_nettype wire

// File: verification/arith_opcode_decoder_bench.sv
// Self-checking bench for the arithmetic opcode decoder
`timescale 1ns/100ps
`default_nettype none
`include "arith_decoder_consts.vh"
module arith_opcode_decoder_bench;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic       push = 1'b0;
  logic       gap = 1'b0;
  logic       op_ready = 1'b0;
  logic [7:0] push_byte = 8'h00;
  wire        byte_valid, byte_ready, op_valid, op_writes;
  wire        op_seg_valid, op_unknown;
  wire  [7:0] byte_data;
  wire  [4:0] op_code;
  wire  [1:0] op_seg;
  wire  [5:0] op_clk_min, op_clk_max;
  wire [15:0] op_imm;
  int         mismatches = 0;
  int         total_checks = 0;
  int         cycles = 0;
  byte_queue_model byte_queue_model_inst (.mclk(mclk), .nrst(nrst),
    .push(push), .push_byte(push_byte), .gap(gap),
    .byte_ready(byte_ready), .byte_valid(byte_valid),
    .byte_data(byte_data));
  arith_opcode_decoder arith_opcode_decoder_inst (.mclk(mclk),
    .nrst(nrst), .byte_valid(byte_valid), .byte_data(byte_data),
    .byte_ready(byte_ready), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_word(), .op_mem(), .op_dir(),
    .op_writes(op_writes), .op_modrm(), .op_imm(op_imm),
    .op_seg_valid(op_seg_valid), .op_seg(op_seg),
    .op_clk_min(op_clk_min), .op_clk_max(op_clk_max),
    .op_unknown(op_unknown));
  always #2.5 mclk = ~mclk;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t: %s", $time, what);
    end
  endtask
  // Queue n bytes, stall lag cycles on both sides, then judge the op
  task automatic run(input logic [31:0] b, input int n,
      input logic [4:0] code, input logic [5:0] mn, input logic [5:0] mx,
      input logic [2:0] sg = 3'h0, input int lag = 0,
      input logic [16:0] im = 17'h00000);
    int i;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge mclk);
      gap <= (lag != 0);
      push <= 1'b1;
      push_byte <= b[8*i +: 8];
    end
    @(posedge mclk);
    push <= 1'b0;
    repeat (lag) @(posedge mclk);
    gap <= 1'b0;
    i = 0;
    while (op_valid !== 1'b1 && i < 40) begin
      @(posedge mclk);
      #1;
      i++;
    end
    repeat (lag) @(posedge mclk);
    #1;
    check(op_valid === 1'b1 && byte_ready === 1'b0, "no op held");
    check(op_code === code && op_unknown === (code == `OP_NONE), "code");
    check(code == `OP_NONE || (op_clk_min === mn && op_clk_max === mx),
      "clock count");
    check(code == `OP_NONE || op_writes ===
      !(code inside {`OP_SEG, `OP_COMPARE}), "writes");
    check(op_seg_valid === sg[2] && (!sg[2] || op_seg === sg[1:0]),
      "segment");
    check(!im[16] || op_imm === im[15:0], "immediate");
    @(posedge mclk);
    op_ready <= 1'b1;
    @(posedge mclk);
    op_ready <= 1'b0;
  endtask
  task automatic t_prefix;
    logic [7:0] pfx [4] = '{8'h2e, 8'h36, 8'h3e, 8'h26};
    logic [1:0] sg [4] = '{`SEG_CODE, `SEG_STACK, `SEG_DATA, `SEG_EXTRA};
    for (int k = 0; k < 4; k++) begin
      run(pfx[k], 1, `OP_SEG, 6'h02, 6'h02, 3'h0, k);
      run(8'h27, 1, `OP_BCD_SUM, 6'h04, 6'h04, {1'b1, sg[k]});
    end
  endtask
  task automatic t_adjust;
    run(8'h37, 1, `OP_ASCII_SUM, 6'h08, 6'h08);
    run(8'h27, 1, `OP_BCD_SUM, 6'h04, 6'h04);
    run(8'h3f, 1, `OP_ASCII_DIF, 6'h07, 6'h07, 3'h0, 3);
    run(8'h2f, 1, `OP_BCD_DIF, 6'h04, 6'h04);
  endtask
  task automatic t_two_op;
    run(16'h00c0, 2, `OP_SUM, 6'h03, 6'h03);
    run(16'h0107, 2, `OP_SUM, 6'h0e, 6'h0e);
    run(16'h1007, 2, `OP_SUM_CARRY, 6'h0a, 6'h0a);
    run(16'h2bc1, 2, `OP_DIFF, 6'h03, 6'h03);
    run(16'h1a07, 2, `OP_DIFF_BORR, 6'h0a, 6'h0a);
    run(16'h3b07, 2, `OP_COMPARE, 6'h0e, 6'h0e);
  endtask
  task automatic t_acc;
    run(24'h053412, 3, `OP_SUM, 6'h04, 6'h04);
    run(16'h1477, 2, `OP_SUM_CARRY, 6'h03, 6'h03);
    run(24'h2d0100, 3, `OP_DIFF, 6'h04, 6'h04);
    run(16'h1c01, 2, `OP_DIFF_BORR, 6'h03, 6'h03);
    run(24'h1d0102, 3, `OP_DIFF_BORR, 6'h04, 6'h04);
  endtask
  task automatic t_imm;
    run(24'h80c005, 3, `OP_SUM, 6'h04, 6'h04);
    run(32'h81170500, 4, `OP_SUM_CARRY, 6'h14, 6'h14, 3'h0, 0,
      17'h10005);
    run(24'h83e8ff, 3, `OP_DIFF, 6'h04, 6'h04, 3'h0, 0,
      17'h1ffff);
    run(24'h82c005, 3, `OP_SUM, 6'h04, 6'h04);
    run(24'h801f05, 3, `OP_DIFF_BORR, 6'h10, 6'h10);
    run(32'h81f80102, 4, `OP_COMPARE, 6'h03, 6'h03);
    run(24'h833fff, 3, `OP_COMPARE, 6'h0e, 6'h0e);
  endtask
  task automatic t_step;
    run(8'h40, 1, `OP_STEP_UP, 6'h03, 6'h03);
    run(8'h4f, 1, `OP_STEP_DOWN, 6'h03, 6'h03);
    run(16'hfe07, 2, `OP_STEP_UP, 6'h0f, 6'h0f);
    run(16'hff0f, 2, `OP_STEP_DOWN, 6'h13, 6'h13);
    run(16'hffc8, 2, `OP_STEP_DOWN, 6'h03, 6'h03);
  endtask
  task automatic t_group3;
    run(16'hf6d8, 2, `OP_SIGN_FLIP, 6'h03, 6'h03);
    run(16'hf61f, 2, `OP_SIGN_FLIP, 6'h0a, 6'h0a);
    run(16'hf71f, 2, `OP_SIGN_FLIP, 6'h0e, 6'h0e);
    run(16'hf6e0, 2, `OP_PRODUCT, 6'h1a, 6'h1c);
    run(16'hf7e0, 2, `OP_PRODUCT, 6'h23, 6'h25);
    run(16'hf627, 2, `OP_PRODUCT, 6'h20, 6'h22);
    run(16'hf727, 2, `OP_PRODUCT, 6'h29, 6'h2b, 3'h0, 5);
  endtask
  task automatic t_unknown;
    run(16'hf6f0, 2, `OP_NONE, 6'h00, 6'h00);
    run(8'h37, 1, `OP_ASCII_SUM, 6'h08, 6'h08);
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    t_prefix();
    t_adjust();
    t_two_op();
    t_acc();
    t_imm();
    t_step();
    t_group3();
    t_unknown();
    tally_and_finish();
  end
endmodule
`default_nettype wire
